// File: hdl/ppg_gate.sv
// Functional notes
// - Power state field encodes D0 as 00 and D3hot as 11.
// - Writes of 01 or 10 leave the power state field unchanged.
// - No-soft-reset bit reads zero; state survives D3hot to D0.
// - In D3hot only own Type 0 configuration requests are acknowledged; others get an Unsupported Request answer.
// - In D3hot no configuration request is forwarded downstream.
// - In D3hot memory and I/O requests are not claimed.
// - In D3hot no memory, I/O or configuration request is initiated.
// - In D3hot memory requests in interrupt controller range still pass.
// - Blocked inbound requests in D3hot get an Unsupported Request answer.
// - Messages and completions always pass in both directions.
`timescale 1ns/1ps
module ppg_gate (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  // Configuration requests arriving at the port
  input  wire logic                  cfg_req_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_type1_i,
  input  wire logic                  cfg_own_i,
  input  wire logic [11:0]           cfg_addr_i,
  input  wire logic [3:0]            cfg_be_i,
  input  wire logic [31:0]           cfg_wdata_i,
  // Configuration answers
  output logic                       cfg_ack_o,
  output logic                       cfg_ur_o,
  output logic                       cfg_fwd_o,
  output logic [31:0]                cfg_rdata_o,
  // Decode enables from the command register
  input  wire logic                  memory_decode_enable_i,
  input  wire logic                  io_decode_enable_i,
  // Interrupt controller window
  input  wire logic [31:0]           interrupt_controller_range_base_i,
  input  wire logic [31:0]           interrupt_controller_range_limit_i,
  // Inbound transactions
  input  wire logic                  in_valid_i,
  input  wire ppg_pkg::ppg_kind_e    in_kind_i,
  input  wire logic [31:0]           in_addr_i,
  input  wire logic                  in_hit_i,
  // Inbound verdicts
  output logic                       in_claim_o,
  output logic                       in_fwd_o,
  output logic                       in_ur_o,
  // Requests the port wants to initiate
  input  wire logic                  init_req_i,
  input  wire ppg_pkg::ppg_kind_e    init_kind_i,
  input  wire logic                  init_is_cfg_i,
  output logic                       init_allow_o,
  // Power state
  output logic                       d3hot_o
);

  ppg_pm_if pm ();

  logic        d3;
  logic        own0;
  logic        reg_hit;
  logic        irq_hit;
  logic        is_req;

  logic        next_cfg_ack;
  logic        next_cfg_ur;
  logic        next_cfg_fwd;
  logic [31:0] next_cfg_rdata;
  logic        next_in_claim;
  logic        next_in_fwd;
  logic        next_in_ur;
  logic        next_d3hot;

  ppg_pm_reg u_pm_reg (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pm         (pm.regs)
  );

  assign d3      = (pm.state == ppg_pkg::PS_D3HOT);
  assign own0    = !cfg_type1_i && cfg_own_i;
  assign reg_hit = (cfg_addr_i[11:2] == ppg_pkg::POWER_MGMT_CONTROL_STATUS_OFS[11:2]);
  assign irq_hit = (in_addr_i >= interrupt_controller_range_base_i) &&
                   (in_addr_i <= interrupt_controller_range_limit_i);
  assign is_req  = (in_kind_i == ppg_pkg::TK_MEM) || (in_kind_i == ppg_pkg::TK_IO);

  // Power state write from own configuration access, low byte lane only
  assign pm.wr_en = cfg_req_i && own0 && cfg_wr_i && reg_hit && cfg_be_i[0];
  assign pm.wdata = cfg_wdata_i[7:0];

  // Configuration path
  always_comb begin
    next_cfg_ack   = 1'b0;
    next_cfg_ur    = 1'b0;
    next_cfg_fwd   = 1'b0;
    next_cfg_rdata = 32'h0000_0000;
    if (cfg_req_i) begin
      if (own0) begin
        next_cfg_ack = 1'b1;
        if (!cfg_wr_i && reg_hit) begin
          next_cfg_rdata = {24'h00_0000, pm.rbyte};
        end
      end else if (d3) begin
        next_cfg_ur = 1'b1;
      end else begin
        next_cfg_fwd = 1'b1;
      end
    end
  end

  // Inbound filter
  always_comb begin
    next_in_claim = 1'b0;
    next_in_fwd   = 1'b0;
    next_in_ur    = 1'b0;
    if (in_valid_i) begin
      case (in_kind_i)
        ppg_pkg::TK_MEM: begin
          if (!d3) begin
            next_in_claim = memory_decode_enable_i && in_hit_i;
            next_in_fwd   = !(memory_decode_enable_i && in_hit_i);
          end else if (irq_hit) begin
            next_in_fwd = 1'b1;
          end else begin
            next_in_ur = 1'b1;
          end
        end
        ppg_pkg::TK_IO: begin
          if (!d3) begin
            next_in_claim = io_decode_enable_i && in_hit_i;
            next_in_fwd   = !(io_decode_enable_i && in_hit_i);
          end else begin
            next_in_ur = 1'b1;
          end
        end
        ppg_pkg::TK_MSG: next_in_fwd = 1'b1;
        ppg_pkg::TK_CPL: next_in_fwd = 1'b1;
        default:         next_in_fwd = 1'b0;
      endcase
    end
  end

  assign next_d3hot = d3;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_ur_o    <= 1'b0;
      cfg_fwd_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
      in_claim_o  <= 1'b0;
      in_fwd_o    <= 1'b0;
      in_ur_o     <= 1'b0;
      d3hot_o     <= 1'b0;
    end else begin
      cfg_ack_o   <= next_cfg_ack;
      cfg_ur_o    <= next_cfg_ur;
      cfg_fwd_o   <= next_cfg_fwd;
      cfg_rdata_o <= next_cfg_rdata;
      in_claim_o  <= next_in_claim;
      in_fwd_o    <= next_in_fwd;
      in_ur_o     <= next_in_ur;
      d3hot_o     <= next_d3hot;
    end
  end

  // Outbound gate; messages and completions never held back
  always_comb begin
    init_allow_o = 1'b0;
    if (init_req_i) begin
      if (init_is_cfg_i) begin
        init_allow_o = !d3;
      end else begin
        case (init_kind_i)
          ppg_pkg::TK_MEM: init_allow_o = !d3;
          ppg_pkg::TK_IO:  init_allow_o = !d3;
          ppg_pkg::TK_MSG: init_allow_o = 1'b1;
          ppg_pkg::TK_CPL: init_allow_o = 1'b1;
          default:         init_allow_o = 1'b0;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  own_cfg_ack_a: assert property (
    cfg_req_i && own0 |=> cfg_ack_o && !cfg_ur_o && !cfg_fwd_o)
    else $error("Own Type 0 request not answered");

  no_cfg_fwd_a: assert property (
    cfg_req_i && !own0 && d3 |=> cfg_ur_o && !cfg_fwd_o && !cfg_ack_o)
    else $error("Configuration request forwarded in D3hot");

  nsr_read_zero_a: assert property (
    cfg_req_i && own0 && !cfg_wr_i && reg_hit && d3
    |=> cfg_rdata_o[3] == 1'b0 && cfg_rdata_o[1:0] == 2'h3)
    else $error("Power state read back wrong");

  mem_blocked_a: assert property (
    in_valid_i && d3 && is_req && !(in_kind_i == ppg_pkg::TK_MEM && irq_hit)
    |=> in_ur_o && !in_claim_o && !in_fwd_o)
    else $error("Memory or I/O request not aborted in D3hot");

  irq_window_a: assert property (
    in_valid_i && d3 && in_kind_i == ppg_pkg::TK_MEM && irq_hit
    |=> in_fwd_o && !in_ur_o)
    else $error("Interrupt controller write blocked in D3hot");

  msg_cpl_pass_a: assert property (
    in_valid_i && !is_req |=> in_fwd_o && !in_ur_o)
    else $error("Message or completion aborted");

  init_gated_a: assert property (
    init_req_i && d3 && (init_is_cfg_i || init_kind_i == ppg_pkg::TK_MEM ||
                         init_kind_i == ppg_pkg::TK_IO)
    |-> !init_allow_o)
    else $error("Request initiated in D3hot");

  d3_write_flag_a: assert property (
    pm.wr_en && pm.wdata[1:0] == 2'h3 |=> ##1 d3hot_o)
    else $error("D3hot state not shown two cycles after write");

  cfg_one_verdict_a: assert property (
    cfg_req_i |=> $onehot({cfg_ack_o, cfg_ur_o, cfg_fwd_o}))
    else $error("Configuration request without exactly one verdict");

  cfg_idle_quiet_a: assert property (
    !cfg_req_i |=> !cfg_ack_o && !cfg_ur_o && !cfg_fwd_o)
    else $error("Configuration verdict without a request");

  d0_cfg_fwd_a: assert property (
    cfg_req_i && !own0 && !d3 |=> cfg_fwd_o && !cfg_ur_o)
    else $error("Configuration request not forwarded in D0");

  rdata_nsr_a: assert property (
    cfg_ack_o |-> cfg_rdata_o[ppg_pkg::NSR_BIT] == ppg_pkg::NSR_VALUE)
    else $error("No-soft-reset bit read back wrong");

  rdata_reserved_a: assert property (
    cfg_ack_o |-> cfg_rdata_o[31:4] == 28'h000_0000 && cfg_rdata_o[2] == 1'b0)
    else $error("Reserved read data bits not zero");

  rdata_code_a: assert property (
    cfg_ack_o |-> cfg_rdata_o[1:0] != ppg_pkg::PS_CODE_D1 &&
                  cfg_rdata_o[1:0] != ppg_pkg::PS_CODE_D2)
    else $error("Unsupported power state code read back");

  d0_read_code_a: assert property (
    cfg_req_i && own0 && !cfg_wr_i && reg_hit && !d3
    |=> cfg_rdata_o[1:0] == ppg_pkg::PS_CODE_D0)
    else $error("D0 not read back as 00");

  other_read_zero_a: assert property (
    cfg_req_i && own0 && !reg_hit |=> cfg_rdata_o == 32'h0000_0000)
    else $error("Read of another offset not zero");

  d0_write_a: assert property (
    pm.wr_en && pm.wdata[1:0] == ppg_pkg::PS_CODE_D0 |=> !d3)
    else $error("D0 write did not leave D3hot");

  state_hold_a: assert property (
    !pm.wr_en |=> $stable(d3))
    else $error("Power state changed without a write");

  flag_follow_a: assert property (
    d3hot_o == $past(d3))
    else $error("D3hot flag does not follow the power state");

  io_blocked_a: assert property (
    in_valid_i && d3 && in_kind_i == ppg_pkg::TK_IO |=> in_ur_o && !in_fwd_o)
    else $error("I/O request not aborted in D3hot");

  d3_no_claim_a: assert property (
    in_valid_i && d3 |=> !in_claim_o)
    else $error("Request claimed in D3hot");

  d0_mem_claim_a: assert property (
    in_valid_i && !d3 && in_kind_i == ppg_pkg::TK_MEM && memory_decode_enable_i && in_hit_i
    |=> in_claim_o && !in_fwd_o)
    else $error("Enabled memory hit not claimed in D0");

  d0_io_claim_a: assert property (
    in_valid_i && !d3 && in_kind_i == ppg_pkg::TK_IO && io_decode_enable_i && in_hit_i
    |=> in_claim_o && !in_fwd_o)
    else $error("Enabled I/O hit not claimed in D0");

  in_one_verdict_a: assert property (
    in_valid_i |=> $onehot({in_claim_o, in_fwd_o, in_ur_o}))
    else $error("Inbound request without exactly one verdict");

  in_idle_quiet_a: assert property (
    !in_valid_i |=> !in_claim_o && !in_fwd_o && !in_ur_o)
    else $error("Inbound verdict without a request");

  msg_cpl_out_a: assert property (
    init_req_i && !init_is_cfg_i &&
    (init_kind_i == ppg_pkg::TK_MSG || init_kind_i == ppg_pkg::TK_CPL) |-> init_allow_o)
    else $error("Outbound message or completion held back");

  d0_init_allow_a: assert property (
    init_req_i && !d3 |-> init_allow_o)
    else $error("Request held back in D0");

  init_idle_a: assert property (
    !init_req_i |-> !init_allow_o)
    else $error("Initiation allowed without a wish");

endmodule

// File: include/ppg_pkg.sv
package ppg_pkg;

  // Configuration address of the power management control and status word
  localparam logic [11:0] POWER_MGMT_CONTROL_STATUS_OFS = 12'h070;

  // Field layout of the low byte
  localparam int PS_LSB  = 0;
  localparam int PS_MSB  = 1;
  localparam int NSR_BIT = 3;

  // Power state encodings and reset value of the low byte
  localparam logic [1:0] PS_CODE_D0    = 2'h0;
  localparam logic [1:0] PS_CODE_D1    = 2'h1;
  localparam logic [1:0] PS_CODE_D2    = 2'h2;
  localparam logic [1:0] PS_CODE_D3HOT = 2'h3;
  localparam logic       NSR_VALUE     = 1'b0;
  localparam logic [7:0] LOW_BYTE_RST  = 8'h00;

  // Transaction classes seen by the filter
  typedef enum logic [1:0] {
    TK_MEM,
    TK_IO,
    TK_MSG,
    TK_CPL
  } ppg_kind_e;

  // Power states the function really supports
  typedef enum logic {
    PS_D0,
    PS_D3HOT
  } ppg_pstate_e;

endpackage

// File: include/ppg_pm_if.sv
`timescale 1ns/1ps
interface ppg_pm_if;
  logic                  wr_en;
  logic [7:0]            wdata;
  ppg_pkg::ppg_pstate_e  state;
  logic [7:0]            rbyte;

  modport ctl (output wr_en, output wdata, input state, input rbyte);
  modport regs (input wr_en, input wdata, output state, output rbyte);
endinterface

// File: hdl/ppg_pm_reg.sv
`timescale 1ns/1ps
module ppg_pm_reg (
  // Clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  sys_rst_i,
  // Register side of the power state link
  ppg_pm_if.regs     pm
);

  ppg_pkg::ppg_pstate_e next_state;
  ppg_pkg::ppg_pstate_e state_q;
  logic [1:0]           code;

  // Only D0 and D3hot codes are taken
  always_comb begin
    next_state = state_q;
    if (pm.wr_en) begin
      case (pm.wdata[ppg_pkg::PS_MSB:ppg_pkg::PS_LSB])
        ppg_pkg::PS_CODE_D0:    next_state = ppg_pkg::PS_D0;
        ppg_pkg::PS_CODE_D3HOT: next_state = ppg_pkg::PS_D3HOT;
        default:                next_state = state_q;
      endcase
    end
  end

  // Only the system reset clears it, never a D3hot exit
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ppg_pkg::PS_D0;
    end else begin
      state_q <= next_state;
    end
  end

  assign code     = (state_q == ppg_pkg::PS_D3HOT) ? ppg_pkg::PS_CODE_D3HOT
                                                   : ppg_pkg::PS_CODE_D0;
  assign pm.state = state_q;
  // Reserved bits and no-soft-reset bit read zero
  assign pm.rbyte = {4'h0, ppg_pkg::NSR_VALUE, 1'b0, code};

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  ignore_bad_code_a: assert property (
    pm.wr_en && (pm.wdata[1:0] == ppg_pkg::PS_CODE_D1 || pm.wdata[1:0] == ppg_pkg::PS_CODE_D2)
    |=> $stable(state_q))
    else $error("Unsupported power state code changed the state");

  take_d3_code_a: assert property (
    pm.wr_en && pm.wdata[1:0] == ppg_pkg::PS_CODE_D3HOT
    |=> pm.rbyte[1:0] == 2'h3 && state_q == ppg_pkg::PS_D3HOT)
    else $error("D3hot write did not read back as 11");

  reserved_zero_a: assert property (
    pm.rbyte[7:2] == 6'h00)
    else $error("Reserved or no-soft-reset bits not zero");

endmodule

// File: tb/ppg_host_model.sv
`timescale 1ns/1ps
// Host software and link partner issuing requests
module ppg_host_model (
  // Clock
  input  wire logic          core_clk_i,
  // Config requests
  output logic               cfg_req_o,
  output logic               cfg_wr_o,
  output logic               cfg_type1_o,
  output logic               cfg_own_o,
  output logic [11:0]        cfg_addr_o,
  output logic [3:0]         cfg_be_o,
  output logic [31:0]        cfg_wdata_o,
  // Inbound transactions
  output logic               in_valid_o,
  output ppg_pkg::ppg_kind_e in_kind_o,
  output logic [31:0]        in_addr_o,
  output logic               in_hit_o
);
  initial begin
    {cfg_req_o, cfg_wr_o, cfg_type1_o, cfg_own_o, in_valid_o, in_hit_o} = '0;
    {cfg_addr_o, cfg_be_o, cfg_wdata_o, in_addr_o} = '0;
    in_kind_o = ppg_pkg::TK_MSG;
  end

  // One-cycle config pulse; returns once the verdict is settled
  task cfg(input logic wr, input logic t1, input logic own, input logic [11:0] addr,
           input logic [3:0] be, input logic [31:0] data);
    @(negedge core_clk_i);
    {cfg_wr_o, cfg_type1_o, cfg_own_o} = {wr, t1, own};
    {cfg_addr_o, cfg_be_o, cfg_wdata_o} = {addr, be, data};
    cfg_req_o = 1'b1;
    @(negedge core_clk_i);
    cfg_req_o = 1'b0;
    // Released address and write data lines do not keep their old value
    {cfg_addr_o, cfg_wdata_o} = ~{cfg_addr_o, cfg_wdata_o};
  endtask

  // One-cycle inbound pulse
  task inb(input ppg_pkg::ppg_kind_e kind, input logic [31:0] addr, input logic hit);
    @(negedge core_clk_i);
    in_kind_o = kind;
    {in_addr_o, in_hit_o} = {addr, hit};
    in_valid_o = 1'b1;
    @(negedge core_clk_i);
    in_valid_o = 1'b0;
    in_addr_o = ~in_addr_o;
  endtask
endmodule

// File: tb/pcie_port_power_state_gate_tb.sv
`timescale 1ns/1ps
module pcie_port_power_state_gate_tb;
  logic clk, rst, mem_en, io_en, init_req, init_cfg, init_allow, d3hot;
  logic req, wr, t1, own, hit, ack, ur, fwd, iv, claim, ifwd, iur;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, ia;
  ppg_pkg::ppg_kind_e ik, init_kind;
  int err_total = 0;
  int checks = 0;
  localparam logic [31:0] BASE = 32'h8000_0000;
  localparam logic [31:0] LIM = 32'h8000_0FFF;

  ppg_host_model host (.core_clk_i(clk), .cfg_req_o(req), .cfg_wr_o(wr), .cfg_type1_o(t1),
    .cfg_own_o(own), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wd), .in_valid_o(iv),
    .in_kind_o(ik), .in_addr_o(ia), .in_hit_o(hit));

  ppg_gate dut (.core_clk_i(clk), .sys_rst_i(rst), .cfg_req_i(req), .cfg_wr_i(wr),
    .cfg_type1_i(t1), .cfg_own_i(own), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd),
    .cfg_ack_o(ack), .cfg_ur_o(ur), .cfg_fwd_o(fwd), .cfg_rdata_o(rdata),
    .memory_decode_enable_i(mem_en), .io_decode_enable_i(io_en),
    .interrupt_controller_range_base_i(BASE), .interrupt_controller_range_limit_i(LIM),
    .in_valid_i(iv), .in_kind_i(ik), .in_addr_i(ia), .in_hit_i(hit), .in_claim_o(claim),
    .in_fwd_o(ifwd), .in_ur_o(iur), .init_req_i(init_req), .init_kind_i(init_kind),
    .init_is_cfg_i(init_cfg), .init_allow_o(init_allow), .d3hot_o(d3hot));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task complete_run;
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Config access; verdict {ack, ur, fwd}
  task cf(input logic w, input logic ty1, input logic ow, input logic [11:0] a,
          input logic [3:0] b, input logic [31:0] d, input logic [2:0] ev, input logic [7:0] ed);
    host.cfg(w, ty1, ow, a, b, d);
    cmp("cfg verdict", {29'h0, ev}, {29'h0, ack, ur, fwd});
    if (ev == 3'h4 && !w) cmp("cfg rdata", {24'h0, ed}, rdata);
  endtask

  // Inbound; verdict {claim, fwd, ur}
  task ib(input ppg_pkg::ppg_kind_e k, input logic [31:0] a, input logic h, input logic [2:0] ev);
    host.inb(k, a, h);
    cmp("in verdict", {29'h0, ev}, {29'h0, claim, ifwd, iur});
  endtask

  task ini(input ppg_pkg::ppg_kind_e k, input logic c, input logic ex);
    @(negedge clk);
    init_kind = k;
    {init_req, init_cfg} = {1'b1, c};
    #1 cmp("init allow", {31'h0, ex}, {31'h0, init_allow});
  endtask

  initial begin
    {rst, mem_en, io_en, init_req, init_cfg} = 5'h1F;
    init_kind = ppg_pkg::TK_MSG;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    cf(1'b0, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h00);
    cmp("d3hot", 32'h0, {31'h0, d3hot});
    ini(ppg_pkg::TK_MEM, 1'b0, 1'b1);
    cf(1'b0, 1'b1, 1'b0, 12'h070, 4'h1, 32'h0, 3'h1, 8'h00);
    ib(ppg_pkg::TK_IO, 32'h0000_1000, 1'b1, 3'h4);
    io_en = 1'b0;
    ib(ppg_pkg::TK_IO, 32'h0000_1000, 1'b1, 3'h2);
    mem_en = 1'b0;
    ib(ppg_pkg::TK_MEM, 32'h1000_0000, 1'b1, 3'h2);
    cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h1, 32'hFFFF_FFFF, 3'h4, 8'h00);
    cf(1'b0, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h03);
    cmp("d3hot", 32'h1, {31'h0, d3hot});
    for (int v = 1; v < 3; v++) begin
      cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h1, v, 3'h4, 8'h00);
      cf(1'b0, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h03);
    end
    cf(1'b0, 1'b1, 1'b0, 12'h070, 4'h1, 32'h0, 3'h2, 8'h00);
    cf(1'b1, 1'b0, 1'b0, 12'h070, 4'h1, 32'h0, 3'h2, 8'h00);
    cf(1'b0, 1'b0, 1'b1, 12'h074, 4'h1, 32'h0, 3'h4, 8'h00);
    {mem_en, io_en} = 2'h3;
    ib(ppg_pkg::TK_MEM, BASE, 1'b0, 3'h2);
    ib(ppg_pkg::TK_MEM, LIM, 1'b1, 3'h2);
    ib(ppg_pkg::TK_MEM, LIM + 32'h1, 1'b1, 3'h1);
    ib(ppg_pkg::TK_IO, BASE, 1'b1, 3'h1);
    ib(ppg_pkg::TK_MSG, 32'h0000_0040, 1'b0, 3'h2);
    ib(ppg_pkg::TK_CPL, 32'h0000_0080, 1'b0, 3'h2);
    ini(ppg_pkg::TK_MEM, 1'b0, 1'b0);
    ini(ppg_pkg::TK_IO, 1'b0, 1'b0);
    ini(ppg_pkg::TK_MEM, 1'b1, 1'b0);
    ini(ppg_pkg::TK_CPL, 1'b0, 1'b1);
    ini(ppg_pkg::TK_MSG, 1'b0, 1'b1);
    @(negedge clk);
    init_req = 1'b0;
    cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h00);
    cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h1, 32'h2, 3'h4, 8'h00);
    cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h0, 32'h3, 3'h4, 8'h00);
    cf(1'b0, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h00);
    cmp("d3hot", 32'h0, {31'h0, d3hot});
    cf(1'b1, 1'b0, 1'b1, 12'h070, 4'h1, 32'h3, 3'h4, 8'h00);
    @(negedge clk);
    cmp("d3hot", 32'h1, {31'h0, d3hot});
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    cmp("d3hot", 32'h0, {31'h0, d3hot});
    cf(1'b0, 1'b0, 1'b1, 12'h070, 4'h1, 32'h0, 3'h4, 8'h00);
    complete_run;
  end

  initial begin
    #5000;
    err_total++;
    complete_run;
  end
endmodule
